// >>> logic/prio_irq_pkg.sv
`default_nettype none

package prio_irq_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_PRIO_A = 8'h00;
	localparam logic [7:0] OFS_PRIO_H = 8'h1C;
	localparam logic [7:0] OFS_NMI_CTRL = 8'h20;
	localparam logic [7:0] OFS_EXT_CTRL = 8'h24;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h28;
	localparam logic [7:0] OFS_EVT_MASK = 8'h2C;
	localparam logic [7:0] OFS_WINNER = 8'h30;

	// Writable bits of each priority register; reserved fields stay zero
	localparam logic [15:0] PRIO_WMASK_A = 16'hFFFF;
	localparam logic [15:0] PRIO_WMASK_B = 16'hFF00;
	localparam logic [15:0] PRIO_WMASK_C = 16'hFFFF;
	localparam logic [15:0] PRIO_WMASK_D = 16'hFFFF;
	localparam logic [15:0] PRIO_WMASK_E = 16'hFFFF;
	localparam logic [15:0] PRIO_WMASK_F = 16'h00F0;
	localparam logic [15:0] PRIO_WMASK_G = 16'hFF00;
	localparam logic [15:0] PRIO_WMASK_H = 16'hFF00;
	localparam logic [15:0] PRIO_RESET = 16'h0000;

	// Non-maskable control fields
	localparam int NMI_LEVEL_BIT = 15;
	localparam int NMI_EDGE_BIT = 8;
	localparam logic NMI_EDGE_RESET = 1'b0;

	// External control fields
	localparam int EXT_MODE_BIT = 14;
	localparam logic EXT_MODE_RESET = 1'b0;
	localparam logic [11:0] EXT_SENSE_RESET = 12'h000;

	// Sense encodings of one 2-bit field
	localparam logic [1:0] SENSE_FALL = 2'h0;
	localparam logic [1:0] SENSE_RISE = 2'h1;
	localparam logic [1:0] SENSE_LOW = 2'h2;
	localparam logic [1:0] SENSE_HIGH = 2'h3;

	// Event status layout: bit 0 non-maskable edge, bits 6..1 ext edges
	localparam int EVT_W = 7;
	localparam logic [EVT_W-1:0] EVT_RESET = 7'h00;

	// Source indices presented to the core
	localparam int NUM_PERIPH = 15;
	localparam int SRC_EXT0 = 15;
	localparam int SRC_PORT_LO = 21;
	localparam int SRC_PORT_HI = 22;
	localparam int SRC_ENCODED = 23;
	localparam int NUM_SRC = 24;
	localparam logic [4:0] SRC_NONE = 5'h1F;

endpackage

`default_nettype wire

// >>> logic/priority_interrupt_unit.sv
`timescale 1ns/10ps
`default_nettype none

module priority_interrupt_unit (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// On-chip peripheral level requests, same clock
	input wire logic timer_chan_a_in,
	input wire logic timer_chan_b_in,
	input wire logic timer_chan_c_in,
	input wire logic calendar_in,
	input wire logic watchdog_src_in,
	input wire logic refresh_in,
	input wire logic dma_src_in,
	input wire logic serial_chan_a_in,
	input wire logic serial_chan_c_in,
	input wire logic converter_in,
	input wire logic usb_in,
	input wire logic pulse_unit_a_in,
	input wire logic pulse_unit_b_in,
	input wire logic pulse_unit_c_in,
	input wire logic pulse_unit_d_in,
	// Device pins
	input wire logic [5:0] ext_request_pins_in,
	input wire logic [15:0] port_request_pins_in,
	input wire logic nonmask_pin_in,
	// Core side
	input wire logic core_ack_in,
	input wire logic [4:0] core_ack_src_in,
	input wire logic core_nmi_ack_in,
	output logic [3:0] core_level_out,
	output logic [4:0] core_src_out,
	output logic core_nmi_out,
	// Event interrupt
	output logic irq_out
);

	// Reset release
	logic rst_m_r;
	logic rst_n_r;

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_m_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_r <= rst_m_r;
		end
	end

	// Pin synchronisers; third stage only for edge history
	logic [22:0] pin_s1_r;
	logic [22:0] pin_s2_r;
	logic [22:0] pin_prev_r;

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_s1_r <= 23'h000000;
			pin_s2_r <= 23'h000000;
			pin_prev_r <= 23'h000000;
		end else begin
			pin_s1_r <= {nonmask_pin_in, port_request_pins_in,
				ext_request_pins_in};
			pin_s2_r <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
		end
	end

	logic [5:0] ext_lvl;
	logic [5:0] ext_old;
	logic [15:0] port_lvl;
	logic nmi_lvl;
	logic nmi_old;

	assign ext_lvl = pin_s2_r[5:0];
	assign ext_old = pin_prev_r[5:0];
	assign port_lvl = pin_s2_r[21:6];
	assign nmi_lvl = pin_s2_r[22];
	assign nmi_old = pin_prev_r[22];

	// Register file
	logic [15:0] prio_r [8];
	logic nmi_edge_r;
	logic ext_mode_r;
	logic [11:0] ext_sense_r;
	localparam int EVT_W_L = prio_irq_pkg::EVT_W;
	logic [EVT_W_L-1:0] evt_status_r;
	logic [EVT_W_L-1:0] evt_mask_r;

	function automatic logic [15:0] prio_wmask(input logic [2:0] idx);
		case (idx)
			3'h0: prio_wmask = prio_irq_pkg::PRIO_WMASK_A;
			3'h1: prio_wmask = prio_irq_pkg::PRIO_WMASK_B;
			3'h2: prio_wmask = prio_irq_pkg::PRIO_WMASK_C;
			3'h3: prio_wmask = prio_irq_pkg::PRIO_WMASK_D;
			3'h4: prio_wmask = prio_irq_pkg::PRIO_WMASK_E;
			3'h5: prio_wmask = prio_irq_pkg::PRIO_WMASK_F;
			3'h6: prio_wmask = prio_irq_pkg::PRIO_WMASK_G;
			default: prio_wmask = prio_irq_pkg::PRIO_WMASK_H;
		endcase
	endfunction

	// Field n of register r, field 0 at bits 15..12
	function automatic logic [3:0] field(input logic [15:0] r,
		input int n);
		field = r[(3 - n) * 4 +: 4];
	endfunction

	logic prio_hit;
	logic [2:0] prio_idx;

	assign prio_hit = reg_addr_in >= prio_irq_pkg::OFS_PRIO_A &&
		reg_addr_in <= prio_irq_pkg::OFS_PRIO_H &&
		reg_addr_in[1:0] == 2'h0;
	assign prio_idx = reg_addr_in[4:2];

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			for (int i = 0; i < 8; i++) begin
				prio_r[i] <= prio_irq_pkg::PRIO_RESET;
			end
		end else if (reg_wr_in && prio_hit) begin
			// Reserved fields never store, so they read zero
			prio_r[prio_idx] <= reg_wdata_in & prio_wmask(prio_idx);
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			nmi_edge_r <= prio_irq_pkg::NMI_EDGE_RESET;
		end else if (reg_wr_in &&
			reg_addr_in == prio_irq_pkg::OFS_NMI_CTRL) begin
			nmi_edge_r <= reg_wdata_in[prio_irq_pkg::NMI_EDGE_BIT];
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ext_mode_r <= prio_irq_pkg::EXT_MODE_RESET;
			ext_sense_r <= prio_irq_pkg::EXT_SENSE_RESET;
		end else if (reg_wr_in &&
			reg_addr_in == prio_irq_pkg::OFS_EXT_CTRL) begin
			ext_mode_r <= reg_wdata_in[prio_irq_pkg::EXT_MODE_BIT];
			ext_sense_r <= reg_wdata_in[11:0];
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			evt_mask_r <= prio_irq_pkg::EVT_RESET;
		end else if (reg_wr_in &&
			reg_addr_in == prio_irq_pkg::OFS_EVT_MASK) begin
			evt_mask_r <= reg_wdata_in[EVT_W_L-1:0];
		end
	end

	// Edge and level detection of the external pins
	logic [5:0] ext_edge;
	logic [5:0] ext_level_req;
	logic nmi_event;

	always_comb begin
		for (int i = 0; i < 6; i++) begin
			case (ext_sense_r[2*i +: 2])
				prio_irq_pkg::SENSE_FALL: begin
					ext_edge[i] = ext_old[i] & ~ext_lvl[i];
					ext_level_req[i] = 1'b0;
				end
				prio_irq_pkg::SENSE_RISE: begin
					ext_edge[i] = ~ext_old[i] & ext_lvl[i];
					ext_level_req[i] = 1'b0;
				end
				prio_irq_pkg::SENSE_LOW: begin
					ext_edge[i] = 1'b0;
					ext_level_req[i] = ~ext_lvl[i];
				end
				default: begin
					ext_edge[i] = 1'b0;
					ext_level_req[i] = ext_lvl[i];
				end
			endcase
		end
		// Encoded mode takes pins 3..0 away from single requests
		if (ext_mode_r) begin
			ext_edge[3:0] = 4'h0;
			ext_level_req[3:0] = 4'h0;
		end
	end

	assign nmi_event = nmi_edge_r ? (~nmi_old & nmi_lvl) :
		(nmi_old & ~nmi_lvl);

	// Latched edge requests, held until the core takes them
	logic [5:0] ext_pend_r;
	logic [5:0] ext_ack;

	always_comb begin
		for (int i = 0; i < 6; i++) begin
			ext_ack[i] = core_ack_in &&
				core_ack_src_in == 5'(prio_irq_pkg::SRC_EXT0 + i);
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ext_pend_r <= 6'h00;
		end else begin
			// A new edge wins over a same-cycle acknowledge
			ext_pend_r <= (ext_pend_r & ~ext_ack) | ext_edge;
		end
	end

	// Non-maskable request bypasses every level and mask
	logic nmi_pend_r;

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_pend_r <= (nmi_pend_r & ~core_nmi_ack_in) | nmi_event;
		end
	end

	// Event status, write one to clear, set wins
	logic [EVT_W_L-1:0] evt_set;
	logic [EVT_W_L-1:0] evt_clr;

	assign evt_set = {ext_edge, nmi_event};
	assign evt_clr = (reg_wr_in &&
		reg_addr_in == prio_irq_pkg::OFS_EVT_STATUS) ?
		reg_wdata_in[EVT_W_L-1:0] : {EVT_W_L{1'b0}};

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			evt_status_r <= prio_irq_pkg::EVT_RESET;
		end else begin
			evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
		end
	end

	assign irq_out = |(evt_status_r & evt_mask_r);

	// Source requests and their levels
	logic [prio_irq_pkg::NUM_SRC-1:0] src_req;
	logic [3:0] src_lvl [prio_irq_pkg::NUM_SRC];
	logic [5:0] ext_req;

	assign ext_req = ext_pend_r | ext_level_req;

	always_comb begin
		src_req = {prio_irq_pkg::NUM_SRC{1'b0}};
		src_req[prio_irq_pkg::NUM_PERIPH-1:0] = {pulse_unit_d_in,
			pulse_unit_c_in, pulse_unit_b_in, pulse_unit_a_in, usb_in,
			converter_in, serial_chan_c_in, serial_chan_a_in, dma_src_in,
			refresh_in, watchdog_src_in, calendar_in, timer_chan_c_in,
			timer_chan_b_in, timer_chan_a_in};
		src_req[prio_irq_pkg::SRC_EXT0 +: 6] = ext_req;
		src_req[prio_irq_pkg::SRC_PORT_LO] = |port_lvl[7:0];
		src_req[prio_irq_pkg::SRC_PORT_HI] = |port_lvl[15:8];
		// Encoded pins are active low; all high means no request
		src_req[prio_irq_pkg::SRC_ENCODED] = ext_mode_r &&
			ext_lvl[3:0] != 4'hF;
	end

	always_comb begin
		// Fixed field map of sources onto registers A to H
		src_lvl[0] = field(prio_r[0], 0);
		src_lvl[1] = field(prio_r[0], 1);
		src_lvl[2] = field(prio_r[0], 2);
		src_lvl[3] = field(prio_r[0], 3);
		src_lvl[4] = field(prio_r[1], 0);
		src_lvl[5] = field(prio_r[1], 1);
		src_lvl[6] = field(prio_r[4], 0);
		src_lvl[7] = field(prio_r[4], 1);
		src_lvl[8] = field(prio_r[4], 2);
		src_lvl[9] = field(prio_r[4], 3);
		src_lvl[10] = field(prio_r[5], 2);
		src_lvl[11] = field(prio_r[6], 0);
		src_lvl[12] = field(prio_r[6], 1);
		src_lvl[13] = field(prio_r[7], 0);
		src_lvl[14] = field(prio_r[7], 1);
		src_lvl[15] = field(prio_r[2], 3);
		src_lvl[16] = field(prio_r[2], 2);
		src_lvl[17] = field(prio_r[2], 1);
		src_lvl[18] = field(prio_r[2], 0);
		src_lvl[19] = field(prio_r[3], 3);
		src_lvl[20] = field(prio_r[3], 2);
		src_lvl[21] = field(prio_r[3], 0);
		src_lvl[22] = field(prio_r[3], 1);
		// Encoded pins carry their own level, inverted
		src_lvl[23] = ~ext_lvl[3:0];
	end

	// Arbitration: highest level, lowest index on a tie
	logic [3:0] win_lvl;
	logic [4:0] win_src;

	always_comb begin
		win_lvl = 4'h0;
		win_src = prio_irq_pkg::SRC_NONE;
		for (int i = 0; i < prio_irq_pkg::NUM_SRC; i++) begin
			// Level zero never beats the idle value, so it masks
			if (src_req[i] && src_lvl[i] > win_lvl) begin
				win_lvl = src_lvl[i];
				win_src = 5'(i);
			end
		end
	end

	logic [3:0] core_level_r;
	logic [4:0] core_src_r;

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			core_level_r <= 4'h0;
			core_src_r <= prio_irq_pkg::SRC_NONE;
		end else begin
			core_level_r <= win_lvl;
			core_src_r <= win_src;
		end
	end

	assign core_level_out = core_level_r;
	assign core_src_out = core_src_r;
	assign core_nmi_out = nmi_pend_r;

	// Read data, one cycle after the strobe; unmapped reads zero
	logic [15:0] rdata_nxt;
	logic [15:0] rdata_r;

	always_comb begin
		rdata_nxt = 16'h0000;
		if (prio_hit) begin
			rdata_nxt = prio_r[prio_idx];
		end else if (reg_addr_in == prio_irq_pkg::OFS_NMI_CTRL) begin
			// Other bits stay zero
			rdata_nxt[prio_irq_pkg::NMI_LEVEL_BIT] = nmi_lvl;
			rdata_nxt[prio_irq_pkg::NMI_EDGE_BIT] = nmi_edge_r;
		end else if (reg_addr_in == prio_irq_pkg::OFS_EXT_CTRL) begin
			rdata_nxt[prio_irq_pkg::EXT_MODE_BIT] = ext_mode_r;
			rdata_nxt[11:0] = ext_sense_r;
		end else if (reg_addr_in == prio_irq_pkg::OFS_EVT_STATUS) begin
			rdata_nxt[EVT_W_L-1:0] = evt_status_r;
		end else if (reg_addr_in == prio_irq_pkg::OFS_EVT_MASK) begin
			rdata_nxt[EVT_W_L-1:0] = evt_mask_r;
		end else if (reg_addr_in == prio_irq_pkg::OFS_WINNER) begin
			rdata_nxt = {7'h00, core_src_r, core_level_r};
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd_in) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	assign reg_rdata_out = rdata_r;

endmodule

`default_nettype wire

// >>> sim/prio_irq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module prio_irq_asserts (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	// Pins and core side
	input wire logic nonmask_pin_in,
	input wire logic core_nmi_ack_in,
	input wire logic [3:0] core_level_out,
	input wire logic [4:0] core_src_out,
	input wire logic core_nmi_out
);
	logic sel_r;
	logic [15:0] keep_r;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	// Edge select as software last wrote it
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sel_r <= 1'b0;
		end else if (reg_wr_in &&
			reg_addr_in == prio_irq_pkg::OFS_NMI_CTRL) begin
			sel_r <= reg_wdata_in[prio_irq_pkg::NMI_EDGE_BIT];
		end
	end
	// Storable bits of the priority register being read
	always_ff @(posedge clock_in) begin
		case (reg_addr_in[4:2])
			3'h1: keep_r <= prio_irq_pkg::PRIO_WMASK_B;
			3'h5: keep_r <= prio_irq_pkg::PRIO_WMASK_F;
			3'h6: keep_r <= prio_irq_pkg::PRIO_WMASK_G;
			3'h7: keep_r <= prio_irq_pkg::PRIO_WMASK_H;
			default: keep_r <= 16'hFFFF;
		endcase
	end
	// Sync needs time, so demand a steady pin first
	sequence pin_steady;
		$stable(nonmask_pin_in) [*4];
	endsequence
	sequence pin_quiet;
		$stable(nonmask_pin_in) [*5];
	endsequence
	AST_PRIO_RSVD: assert property (
		reg_rd_in && reg_addr_in < 8'h20
		|=> (reg_rdata_out & ~keep_r) == 16'h0000)
		else $error("reserved priority field not zero");
	AST_NMI_RSVD: assert property (
		reg_rd_in && reg_addr_in == prio_irq_pkg::OFS_NMI_CTRL
		|=> reg_rdata_out[14:9] == 6'h00 && reg_rdata_out[7:0] == 8'h00)
		else $error("reserved control bits not zero");
	AST_NMI_LEVEL: assert property (
		pin_steady ##0
		(reg_rd_in && reg_addr_in == prio_irq_pkg::OFS_NMI_CTRL)
		|=> reg_rdata_out[15] == $past(nonmask_pin_in))
		else $error("pin level bit wrong");
	AST_NMI_EDGE: assert property (
		(sel_r && $rose(nonmask_pin_in)) || (!sel_r && $fell(nonmask_pin_in))
		|-> ##[1:6] core_nmi_out)
		else $error("selected edge not requested");
	AST_NMI_HOLD: assert property (
		core_nmi_out && !core_nmi_ack_in |=> core_nmi_out)
		else $error("non-maskable request dropped early");
	AST_NMI_ACK: assert property (
		pin_quiet ##0 core_nmi_ack_in |=> !core_nmi_out)
		else $error("non-maskable request kept after ack");
	AST_NONE_PAIR: assert property (
		(core_level_out == 4'h0) == (core_src_out == prio_irq_pkg::SRC_NONE))
		else $error("level and source disagree");
	AST_SRC_LEGAL: assert property (
		core_level_out != 4'h0 |-> core_src_out <= 5'h17)
		else $error("winner index out of range");
endmodule
`default_nettype wire

// >>> sim/core_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_model (
	// Clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// Bench control
	input wire logic ack_en_in,
	input wire logic [3:0] wait_in,
	// Controller side
	input wire logic [3:0] level_in,
	input wire logic [4:0] src_in,
	input wire logic nmi_in,
	output logic ack_out,
	output logic [4:0] ack_src_out,
	output logic nmi_ack_out
);
	logic [3:0] cnt_r;
	logic want;
	assign want = ack_en_in && (nmi_in || level_in != 4'h0);
	// Slow core waits wait_in cycles before taking a request
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= 4'h0;
			ack_out <= 1'b0;
			ack_src_out <= 5'h00;
			nmi_ack_out <= 1'b0;
		end else begin
			ack_out <= 1'b0;
			nmi_ack_out <= 1'b0;
			cnt_r <= 4'h0;
			if (want && !ack_out && !nmi_ack_out) begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == wait_in) begin
					cnt_r <= 4'h0;
					ack_out <= level_in != 4'h0;
					ack_src_out <= src_in;
					// Taken whatever the core's own mask
					nmi_ack_out <= nmi_in;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock_in, resetn_in, reg_wr_in, reg_rd_in, nonmask_pin_in;
	logic [7:0] reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, port, d;
	logic [14:0] per;
	logic [5:0] ext;
	logic [3:0] core_level_out, wait_r;
	logic [4:0] core_src_out, ack_src;
	logic ack, nmi_ack, core_nmi_out, irq_out, ack_en;
	int failures, compares, seed, cyc, lv, sr, mode;
	int prio[8];
	logic [15:0] wm[8] = '{prio_irq_pkg::PRIO_WMASK_A,
		prio_irq_pkg::PRIO_WMASK_B,
		prio_irq_pkg::PRIO_WMASK_C, prio_irq_pkg::PRIO_WMASK_D,
		prio_irq_pkg::PRIO_WMASK_E, prio_irq_pkg::PRIO_WMASK_F,
		prio_irq_pkg::PRIO_WMASK_G, prio_irq_pkg::PRIO_WMASK_H};
	int mreg[23] = '{0,0,0,0,1,1,4,4,4,4,5,6,6,7,7,2,2,2,2,3,3,3,3};
	int msh[23] = '{12,8,4,0,12,8,12,8,4,0,4,12,8,12,8,0,4,8,12,0,4,12,8};

	priority_interrupt_unit u_priority_interrupt_unit (
		.clock_in(clock_in), .resetn_in(resetn_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.timer_chan_a_in(per[0]), .timer_chan_b_in(per[1]),
		.timer_chan_c_in(per[2]), .calendar_in(per[3]),
		.watchdog_src_in(per[4]), .refresh_in(per[5]), .dma_src_in(per[6]),
		.serial_chan_a_in(per[7]), .serial_chan_c_in(per[8]),
		.converter_in(per[9]), .usb_in(per[10]), .pulse_unit_a_in(per[11]),
		.pulse_unit_b_in(per[12]), .pulse_unit_c_in(per[13]),
		.pulse_unit_d_in(per[14]), .ext_request_pins_in(ext),
		.port_request_pins_in(port), .nonmask_pin_in(nonmask_pin_in),
		.core_ack_in(ack), .core_ack_src_in(ack_src),
		.core_nmi_ack_in(nmi_ack), .core_level_out(core_level_out),
		.core_src_out(core_src_out), .core_nmi_out(core_nmi_out),
		.irq_out(irq_out));

	core_model u_core_model (.clock_in(clock_in), .resetn_in(resetn_in),
		.ack_en_in(ack_en), .wait_in(wait_r), .level_in(core_level_out),
		.src_in(core_src_out), .nmi_in(core_nmi_out), .ack_out(ack),
		.ack_src_out(ack_src), .nmi_ack_out(nmi_ack));

	task automatic chk(input string n, input logic [15:0] s,
		input logic [15:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clock_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		// Data stand only in the cycle after the strobe
		@(posedge clock_in);
		d = reg_rdata_out;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Level-sensed pins only; ties go to the lower index
	function automatic void best(output int l, output int s);
		logic a;
		int v;
		l = 0;
		s = 31;
		for (int i = 0; i < 24; i++) begin
			if (i < 15) a = per[i];
			else if (i < 21) a = ext[i-15] && !(mode != 0 && i < 19);
			else if (i < 23) a = (i == 21) ? |port[7:0] : |port[15:8];
			else a = mode != 0;
			v = (i < 23) ? (prio[mreg[i]] >> msh[i]) & 15 : int'(~ext[3:0]);
			if (a && v > l) begin
				l = v;
				s = i;
			end
		end
	endfunction

	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			test_done;
		end
	end

	initial begin
		seed = 15;
		{resetn_in, reg_wr_in, reg_rd_in, nonmask_pin_in, ack_en} = 5'h00;
		{reg_addr_in, reg_wdata_in, port, per, ext, wait_r} = 0;
		idle(12);
		resetn_in <= 1'b1;
		idle(5);
		for (int a = 0; a < 'h38; a += 4) begin
			rd(8'(a));
			chk("reset", d, (a == 'h30) ? 16'h01F0 : 16'h0000);
		end
		repeat (16) begin
			for (int r = 0; r < 8; r++) begin
				d = 16'($random(seed));
				prio[r] = d & wm[r];
				wr(8'(r * 4), d);
				rd(8'(r * 4));
				chk("prio", d, 16'(prio[r]));
			end
			mode = $random(seed) & 1;
			wr(prio_irq_pkg::OFS_EXT_CTRL, (mode != 0) ? 16'h4FFF : 16'h0FFF);
			per <= 15'($random(seed));
			ext <= 6'($random(seed));
			port <= 16'($random(seed));
			idle(6);
			best(lv, sr);
			chk("level", 16'(core_level_out), 16'(lv));
			chk("source", 16'(core_src_out), 16'(sr));
			rd(prio_irq_pkg::OFS_WINNER);
			chk("winner", d, 16'(sr * 16 + lv));
		end
		for (int r = 0; r < 8; r++)
			wr(8'(r * 4), (r == 2) ? 16'h0009 : 16'h0000);
		per <= 15'h0000;
		port <= 16'h0000;
		for (int c = 0; c < 4; c++) begin
			ext <= {5'h00, c % 2 == 0};
			wr(prio_irq_pkg::OFS_EXT_CTRL, 16'(c));
			idle(6);
			wr(prio_irq_pkg::OFS_EVT_STATUS, 16'h007F);
			wr(prio_irq_pkg::OFS_EVT_MASK, 16'h0002);
			chk("quiet", 16'(core_level_out), 16'h0000);
			ext[0] <= ~ext[0];
			idle(6);
			chk("sensed", {core_src_out, 7'h00, core_level_out},
				{5'(prio_irq_pkg::SRC_EXT0), 7'h00, 4'h9});
			chk("irq", 16'(irq_out), 16'(c < 2));
			ack_en <= 1'b1;
			idle(12);
			ack_en <= 1'b0;
			// Edge latch goes with the ack, a level stays
			chk("acked", 16'(core_level_out), (c < 2) ? 16'h0 : 16'h9);
			wr(prio_irq_pkg::OFS_EVT_STATUS, 16'h0002);
			idle(2);
			chk("cleared", 16'(irq_out), 16'h0000);
		end
		for (int s = 0; s < 2; s++) begin
			wr(prio_irq_pkg::OFS_NMI_CTRL, (s != 0) ? 16'hFFFF : 16'hFEFF);
			nonmask_pin_in <= (s == 0);
			idle(6);
			wr(prio_irq_pkg::OFS_EVT_STATUS, 16'h007F);
			wr(prio_irq_pkg::OFS_EVT_MASK, 16'h0001);
			rd(prio_irq_pkg::OFS_NMI_CTRL);
			chk("nmi ctrl", d, (s != 0) ? 16'h0100 : 16'h8000);
			nonmask_pin_in <= (s != 0);
			idle(6);
			chk("nmi req", 16'({core_nmi_out, irq_out}), 16'h0003);
			wait_r <= 4'h8;
			ack_en <= 1'b1;
			idle(20);
			ack_en <= 1'b0;
			nonmask_pin_in <= (s == 0);
			idle(6);
			chk("wrong edge", 16'(core_nmi_out), 16'h0000);
			rd(prio_irq_pkg::OFS_EVT_STATUS);
			chk("status", d, 16'h0001);
			wr(prio_irq_pkg::OFS_EVT_MASK, 16'h0000);
			idle(2);
			chk("masked", 16'(irq_out), 16'h0000);
		end
		test_done;
	end
endmodule

bind priority_interrupt_unit prio_irq_asserts u_prio_irq_asserts (
	.clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.nonmask_pin_in(nonmask_pin_in), .core_nmi_ack_in(core_nmi_ack_in),
	.core_level_out(core_level_out), .core_src_out(core_src_out),
	.core_nmi_out(core_nmi_out));
`default_nettype wire
